// ===== rtl/mrxc_top.sv
`timescale 1ns/1ps
`include "mrxc_map.svh"
// Behaviour
// - Good-frame enable interrupts on error-free frames
// - FIFO parity enable interrupts on parity error
// - Length enable interrupts on length-field error
// - Oversize enable interrupts beyond 1518/1522 bytes
// - Overflow enable interrupts on full FIFO
// - FCS enable interrupts on bad CRC or rx_er
// - Alignment enable interrupts on odd-bit bad CRC
// - Skip bits disable length and CRC checks
// - Forward control frames instead of consuming them
// - Remove FCS after checking it
// - Accept frames shorter than 64 bytes
// - Accept frames beyond 1518/1522 bytes
// - Stop request halts after current frame
// - Enable cleared after DA: finish, then stopped
// - Enable cleared before DA: stop at once
// - Hardware reset zeroes control register
// - Soft reset clears only receive enable
// - Lengths exclude preamble and SFD
// - Stopped flag at status bit 15, resets 1
module mrxc_top
    import mrxc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic soft_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic rx_sof,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_eof,
    input wire logic rx_crc_bad,
    input wire logic rx_dribble,
    input wire logic rx_er,
    input wire logic fifo_full,
    input wire logic fifo_parity_err,
    input wire logic immediate_stop_command,
    output logic rx_irq,
    output logic frame_done,
    output logic frame_keep,
    output logic [15:0] frame_len,
    output mrxc_ev_t frame_events,
    output logic receive_stopped_flag
);
    // ****************************************
    // Register bus
    // ****************************************
    mrxc_ctl_t ctl_q;
    mrxc_ev_t ev_q;
    mrxc_state_t state_q;
    mrxc_state_t state_d;
    logic stopped_q;
    logic irq_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;

    wire logic acc_w = hsel && htrans[1] && hready;
    wire logic rd_acc_w = acc_w && !hwrite;
    wire logic wr_acc_w = acc_w && hwrite;
    wire logic hit_ctl_w = haddr[7:0] == `MRXC_RX_CONTROL_OFS && haddr[31:8] == 24'h000000;
    wire logic hit_sts_w = haddr[7:0] == `MRXC_RX_STATUS_OFS && haddr[31:8] == 24'h000000;
    wire logic [31:0] sts_word_w = {16'h0000, stopped_q, ev_q, 8'h00};
    wire logic [31:0] rdata_w = hit_ctl_w ? {17'h00000, ctl_q} :
                                hit_sts_w ? sts_word_w : 32'h00000000;
    wire logic ctl_wr_w = wr_pend_q && hready && wr_addr_q == `MRXC_RX_CONTROL_OFS;
    wire logic sts_rd_w = rd_acc_w && hit_sts_w;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q <= 32'h00000000;
            hreadyout_q <= 1'b1;
        end else begin
            hreadyout_q <= 1'b1;
            if (hready) begin
                wr_pend_q <= wr_acc_w;
                wr_addr_q <= (wr_acc_w && hit_ctl_w) ? `MRXC_RX_CONTROL_OFS : 8'h00;
                hrdata_q <= rd_acc_w ? rdata_w : 32'h00000000;
            end
        end
    end

    // Soft reset beats a write in the same cycle so the MAC is never left enabled
    wire mrxc_ctl_t ctl_wr_val_w = mrxc_ctl_t'(hwdata[`MRXC_CTRL_W-1:0]);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_q <= mrxc_ctl_t'(`MRXC_CTRL_RESET);
        end else begin
            if (ctl_wr_w) begin
                ctl_q <= ctl_wr_val_w;
            end
            if (soft_rst) begin
                ctl_q.receive_enable <= 1'b0;
            end
        end
    end

    // ****************************************
    // Frame parsing
    // ****************************************
    logic [15:0] len_q;
    logic [15:0] type_q;
    logic [15:0] inner_q;
    logic crc_seen_q;
    logic er_seen_q;
    logic over_seen_q;
    logic par_seen_q;

    wire logic clr_frame_w = state_q == MRXC_IDLE && rx_sof;
    wire logic take_byte_w = rx_byte_valid && (state_q == MRXC_ARMED || state_q == MRXC_RECV);
    wire logic [15:0] len_inc_w = (len_q == 16'hFFFF) ? len_q : len_q + 16'h0001;

    // Length counts from the destination address, preamble and SFD never reach here
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            len_q <= 16'h0000;
            type_q <= 16'h0000;
            inner_q <= 16'h0000;
        end else if (clr_frame_w) begin
            len_q <= 16'h0000;
            type_q <= 16'h0000;
            inner_q <= 16'h0000;
        end else if (take_byte_w) begin
            len_q <= len_inc_w;
            if (len_q == `MRXC_TYPE_POS || len_q == `MRXC_TYPE_POS + 16'h0001) begin
                type_q <= {type_q[7:0], rx_byte};
            end
            if (len_q == `MRXC_INNER_POS || len_q == `MRXC_INNER_POS + 16'h0001) begin
                inner_q <= {inner_q[7:0], rx_byte};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_seen_q <= 1'b0;
            er_seen_q <= 1'b0;
            over_seen_q <= 1'b0;
            par_seen_q <= 1'b0;
        end else if (clr_frame_w) begin
            crc_seen_q <= 1'b0;
            er_seen_q <= 1'b0;
            over_seen_q <= 1'b0;
            par_seen_q <= 1'b0;
        end else begin
            crc_seen_q <= crc_seen_q || rx_crc_bad;
            er_seen_q <= er_seen_q || rx_er;
            over_seen_q <= over_seen_q || (fifo_full && take_byte_w);
            par_seen_q <= par_seen_q || fifo_parity_err;
        end
    end

    // ****************************************
    // Frame verdict at end of frame
    // ****************************************
    wire logic vlan_w = type_q == `MRXC_TPID_VLAN;
    wire logic [15:0] lenfield_w = vlan_w ? inner_q : type_q;
    wire logic [15:0] hdr_w = vlan_w ? `MRXC_VLAN_HDR_BYTES : `MRXC_HDR_BYTES;
    wire logic [15:0] max_w = vlan_w ? `MRXC_MAX_LEN_VLAN : `MRXC_MAX_LEN;
    wire logic [15:0] payload_w = len_q - hdr_w - `MRXC_FCS_BYTES;
    wire logic is_ctl_w = lenfield_w == `MRXC_TYPE_MAC_CTL;
    wire logic too_long_w = len_q > max_w;
    wire logic runt_w = len_q < `MRXC_MIN_LEN;
    wire logic runt_rej_w = runt_w && !ctl_q.accept_runt_frames;
    wire logic long_err_w = too_long_w && !ctl_q.accept_oversize_frames;
    wire logic crc_bad_w = crc_seen_q && !ctl_q.skip_fcs_check;
    wire logic fcs_err_w = crc_bad_w || er_seen_q;
    wire logic exp_pay_w = lenfield_w < `MRXC_MIN_PAYLOAD;
    wire logic pay_bad_w = exp_pay_w ? payload_w != `MRXC_MIN_PAYLOAD : payload_w != lenfield_w;
    // Type values above the limit carry a protocol, not a length
    wire logic len_err_w = !ctl_q.skip_length_check && !runt_w &&
                           lenfield_w <= `MRXC_MAX_TYPE_LEN && pay_bad_w;
    mrxc_ev_t ev_d;
    assign ev_d.parity = par_seen_q;
    assign ev_d.length = len_err_w;
    assign ev_d.oversize = long_err_w;
    assign ev_d.overflow = over_seen_q;
    assign ev_d.fcs = fcs_err_w;
    assign ev_d.align = crc_bad_w && rx_dribble;
    assign ev_d.good = !(par_seen_q || len_err_w || long_err_w || over_seen_q ||
                         fcs_err_w || runt_rej_w);
    wire logic drop_w = runt_rej_w || long_err_w || fcs_err_w || over_seen_q || par_seen_q;
    wire logic keep_w = !drop_w && (!is_ctl_w || ctl_q.forward_control_frames);
    wire logic [15:0] out_len_w = ctl_q.remove_fcs && len_q >= `MRXC_FCS_BYTES ?
                                  len_q - `MRXC_FCS_BYTES : len_q;
    wire mrxc_ev_t en_w = mrxc_ev_t'(ctl_q[`MRXC_EV_MSB:`MRXC_EV_LSB]);

    // ****************************************
    // Reception state and stopping
    // ****************************************
    wire logic running_w = ctl_q.receive_enable && !ctl_q.receive_stop_request;
    wire logic recv_end_w = state_q == MRXC_RECV && rx_eof && !immediate_stop_command;
    wire logic early_stop_w = state_q == MRXC_ARMED && !ctl_q.receive_enable;
    wire logic stop_set_w = immediate_stop_command || early_stop_w ||
                            (state_q == MRXC_IDLE && !running_w) ||
                            (recv_end_w && !running_w);
    wire logic stop_clr_w = state_q == MRXC_IDLE && running_w;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            MRXC_IDLE: begin
                if (rx_sof) begin
                    state_d = (running_w && !stopped_q) ? MRXC_ARMED : MRXC_DISCARD;
                end
            end
            MRXC_ARMED: begin
                if (early_stop_w || immediate_stop_command) begin
                    state_d = rx_eof ? MRXC_IDLE : MRXC_DISCARD;
                end else if (rx_eof) begin
                    state_d = MRXC_IDLE;
                end else if (rx_byte_valid) begin
                    state_d = MRXC_RECV;
                end
            end
            MRXC_RECV: begin
                if (immediate_stop_command) begin
                    state_d = rx_eof ? MRXC_IDLE : MRXC_DISCARD;
                end else if (rx_eof) begin
                    state_d = MRXC_IDLE;
                end
            end
            MRXC_DISCARD: begin
                if (rx_eof) begin
                    state_d = MRXC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= MRXC_IDLE;
            stopped_q <= 1'b1;
        end else begin
            state_q <= state_d;
            if (stop_set_w) begin
                stopped_q <= 1'b1;
            end else if (stop_clr_w) begin
                stopped_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Frame report and interrupt
    // ****************************************
    wire logic irq_hit_w = recv_end_w && |(ev_d & en_w);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_q <= '0;
            irq_q <= 1'b0;
            frame_done <= 1'b0;
            frame_keep <= 1'b0;
            frame_len <= 16'h0000;
        end else begin
            frame_done <= recv_end_w;
            if (recv_end_w) begin
                ev_q <= ev_d;
                frame_keep <= keep_w;
                frame_len <= out_len_w;
            end
            // A new event in the read cycle wins over the read clear
            if (irq_hit_w) begin
                irq_q <= 1'b1;
            end else if (sts_rd_w) begin
                irq_q <= 1'b0;
            end
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign rx_irq = irq_q;
    assign frame_events = ev_q;
    assign receive_stopped_flag = stopped_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_irq_on_event: assert property (irq_hit_w |=> rx_irq && frame_done)
        else $error("enabled frame event did not raise interrupt");
    a_good_irq_set: assert property (recv_end_w && ev_d.good &&
        ctl_q.good_frame_irq_enable |=> rx_irq && frame_events.good)
        else $error("good frame interrupt missing");
    a_halt_after_frame: assert property (recv_end_w && ctl_q.receive_stop_request
        |=> receive_stopped_flag && state_q == MRXC_IDLE)
        else $error("stop request did not halt after frame");
    a_early_stop: assert property (state_q == MRXC_ARMED && !ctl_q.receive_enable
        |=> receive_stopped_flag && state_q != MRXC_RECV && !frame_done)
        else $error("enable clear before address did not stop at once");
    a_finish_frame: assert property (state_q == MRXC_RECV &&
        !ctl_q.receive_enable && !immediate_stop_command && !rx_eof |=> state_q == MRXC_RECV)
        else $error("frame in progress abandoned on enable clear");
    a_soft_reset: assert property (soft_rst |=> !ctl_q.receive_enable &&
        ctl_q[`MRXC_CTRL_W-1:1] == $past(ctl_wr_w ? ctl_wr_val_w[`MRXC_CTRL_W-1:1] :
        ctl_q[`MRXC_CTRL_W-1:1]))
        else $error("soft reset disturbed other control bits");
    a_strip_len: assert property (recv_end_w && ctl_q.remove_fcs &&
        len_q >= 16'h0004 |=> frame_len == $past(len_q) - 16'h0004)
        else $error("delivered length not reduced by FCS");
    a_long_flag: assert property (recv_end_w && len_q > 16'h05EE && !vlan_w &&
        !ctl_q.accept_oversize_frames |=> frame_events.oversize && !frame_keep)
        else $error("oversize frame not flagged");
    a_runt_drop: assert property (recv_end_w && len_q < 16'h0040 &&
        !ctl_q.accept_runt_frames |=> !frame_keep && !frame_events.good)
        else $error("runt frame accepted");
    a_hw_reset: assert property ($rose(rst_b) |-> ctl_q == '0 && receive_stopped_flag)
        else $error("control not zero after reset");

    // ****************************************
    // Frame event checks
    // ****************************************
    a_irq_quiet: assert property (!irq_hit_w && !rx_irq |=> !rx_irq)
        else $error("interrupt raised without an enabled event");
    a_parity_event: assert property (recv_end_w && par_seen_q
        |=> frame_events.parity && !frame_keep)
        else $error("fifo parity error not reported");
    a_length_event: assert property (recv_end_w && len_err_w &&
        ctl_q.length_field_irq_enable |=> rx_irq && frame_events.length)
        else $error("length field error not reported");
    a_overflow_event: assert property (recv_end_w && over_seen_q
        |=> frame_events.overflow && !frame_keep)
        else $error("fifo overflow not reported");
    a_fcs_event: assert property (recv_end_w && er_seen_q
        |=> frame_events.fcs && !frame_keep)
        else $error("receive error not reported as bad crc");
    a_align_event: assert property (recv_end_w && crc_bad_w && rx_dribble
        |=> frame_events.align)
        else $error("alignment error not reported");
    a_skip_fcs: assert property (recv_end_w && ctl_q.skip_fcs_check && !er_seen_q
        |=> !frame_events.fcs)
        else $error("crc checked although skipped");
    a_ctl_frame_drop: assert property (recv_end_w && is_ctl_w &&
        !ctl_q.forward_control_frames |=> !frame_keep)
        else $error("control frame delivered without forwarding");
    a_accept_long: assert property (recv_end_w && ctl_q.accept_oversize_frames
        |=> !frame_events.oversize)
        else $error("oversize flagged although accepted");
    a_disabled_skip: assert property (state_q == MRXC_IDLE && rx_sof && !running_w
        |=> state_q == MRXC_DISCARD)
        else $error("frame taken while reception disabled");
    a_ctl_write: assert property (ctl_wr_w && !soft_rst |=> ctl_q == $past(ctl_wr_val_w))
        else $error("control write did not land");

    // ****************************************
    // Cover points
    // ****************************************
    c_good_frame: cover property (recv_end_w && ev_d.good);
    c_fcs_error: cover property (recv_end_w && ev_d.fcs && ev_d.align);
    c_early_stop: cover property (early_stop_w);
    c_late_stop: cover property (recv_end_w && !ctl_q.receive_enable);
    c_ctl_forward: cover property (recv_end_w && is_ctl_w && keep_w);
endmodule : mrxc_top

// ===== rtl/mrxc_map.svh
`ifndef MRXC_MAP_SVH
`define MRXC_MAP_SVH
// ****************************************
// Register map
// ****************************************
`define MRXC_RX_CONTROL_OFS 8'h50
`define MRXC_RX_STATUS_OFS 8'h54
`define MRXC_CTRL_RESET 15'h0000
`define MRXC_CTRL_W 15
`define MRXC_STOPPED_BIT 15
`define MRXC_EV_LSB 8
`define MRXC_EV_MSB 14
// ****************************************
// Frame limits, bytes without preamble and SFD
// ****************************************
`define MRXC_MIN_LEN 16'h0040
`define MRXC_MAX_LEN 16'h05EE
`define MRXC_MAX_LEN_VLAN 16'h05F2
`define MRXC_MAX_TYPE_LEN 16'h05DC
`define MRXC_HDR_BYTES 16'h000E
`define MRXC_VLAN_HDR_BYTES 16'h0012
`define MRXC_MIN_PAYLOAD 16'h002E
`define MRXC_FCS_BYTES 16'h0004
`define MRXC_TPID_VLAN 16'h8100
`define MRXC_TYPE_MAC_CTL 16'h8808
`define MRXC_TYPE_POS 16'h000C
`define MRXC_INNER_POS 16'h0010
`endif

// ===== rtl/mrxc_pkg.sv
package mrxc_pkg;
    // Control word, bit 14 down to bit 0
    typedef struct packed {
        logic good_frame_irq_enable;
        logic rx_fifo_parity_irq_enable;
        logic length_field_irq_enable;
        logic oversize_irq_enable;
        logic fifo_overflow_irq_enable;
        logic fcs_error_irq_enable;
        logic alignment_irq_enable;
        logic skip_length_check;
        logic skip_fcs_check;
        logic forward_control_frames;
        logic remove_fcs;
        logic accept_runt_frames;
        logic accept_oversize_frames;
        logic receive_stop_request;
        logic receive_enable;
    } mrxc_ctl_t;

    // Frame events, same order as the enables above
    typedef struct packed {
        logic good;
        logic parity;
        logic length;
        logic oversize;
        logic overflow;
        logic fcs;
        logic align;
    } mrxc_ev_t;

    typedef enum logic [1:0] {
        MRXC_IDLE,
        MRXC_ARMED,
        MRXC_RECV,
        MRXC_DISCARD
    } mrxc_state_t;
endpackage : mrxc_pkg

// ===== tb/mrxc_phy_model.sv
`timescale 1ns/1ps
// ****
// Line-side frame source
// ****
module mrxc_phy_model (
    input wire logic sys_clk,
    output logic rx_sof,
    output logic rx_byte_valid,
    output logic [7:0] rx_byte,
    output logic rx_eof,
    output logic rx_crc_bad,
    output logic rx_dribble,
    output logic rx_er,
    output logic fifo_full,
    output logic fifo_parity_err
);
    initial begin
        {rx_sof, rx_byte_valid, rx_eof, rx_crc_bad, rx_dribble} = 5'h00;
        {rx_er, fifo_full, fifo_parity_err} = 3'h0;
        rx_byte = 8'hA5;
    end

    // Bytes counted from the first DA byte
    // Error bits: {parity, full, er, dribble, crc}
    task automatic send(input int len, input logic [15:0] typ, input logic [4:0] err,
                        input int gap);
        logic [7:0] b;
        rx_sof <= 1'b1;
        @(posedge sys_clk);
        rx_sof <= 1'b0;
        repeat (gap) @(posedge sys_clk);
        for (int i = 0; i < len; i++) begin
            b = 8'($urandom);
            if (i == 12) b = typ[15:8];
            if (i == 13) b = typ[7:0];
            if (i == 16) b = 8'h08;
            if (i == 17) b = 8'h00;
            rx_byte_valid <= 1'b1;
            rx_byte <= b;
            fifo_full <= err[3] && i == len / 2;
            rx_crc_bad <= err[0] && i >= len / 2;
            rx_er <= err[2] && i >= len / 2;
            fifo_parity_err <= err[4] && i >= len / 2;
            @(posedge sys_clk);
        end
        // Released data shows no stale byte
        rx_byte_valid <= 1'b0;
        rx_byte <= ~rx_byte;
        fifo_full <= 1'b0;
        rx_eof <= 1'b1;
        rx_dribble <= err[1];
        @(posedge sys_clk);
        {rx_eof, rx_dribble, rx_crc_bad, rx_er, fifo_parity_err} <= 5'h00;
        rx_byte <= rx_byte ^ 8'h5A;
        @(posedge sys_clk);
    endtask : send
endmodule : mrxc_phy_model

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
    import mrxc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b, soft_rst, hsel, hwrite, hready, hreadyout, hresp, immediate_stop_command;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic rx_sof, rx_byte_valid, rx_eof, rx_crc_bad, rx_dribble, rx_er;
    logic fifo_full, fifo_parity_err, rx_irq, frame_done, frame_keep, receive_stopped_flag;
    logic [7:0] rx_byte;
    logic [15:0] frame_len, cap_len;
    mrxc_ev_t frame_events, cap_ev;
    logic cap_keep, cap_irq;
    int fail_count, n_checks, cyc, n_done;

    always #12.5 sys_clk = ~sys_clk;
    assign hready = hreadyout;

    mrxc_top dut (.sys_clk, .rst_b, .soft_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rx_sof, .rx_byte_valid, .rx_byte,
        .rx_eof, .rx_crc_bad, .rx_dribble, .rx_er, .fifo_full, .fifo_parity_err,
        .immediate_stop_command, .rx_irq, .frame_done, .frame_keep, .frame_len,
        .frame_events, .receive_stopped_flag);

    mrxc_phy_model phy (.sys_clk, .rx_sof, .rx_byte_valid, .rx_byte, .rx_eof, .rx_crc_bad,
        .rx_dribble, .rx_er, .fifo_full, .fifo_parity_err);

    // ****
    // Monitor and watchdog
    // ****
    // Sampled mid-cycle, away from the edge that updates them
    always @(negedge sys_clk) begin
        if (frame_done === 1'b1) begin
            n_done++;
            cap_keep = frame_keep;
            cap_len = frame_len;
            cap_ev = frame_events;
            cap_irq = rx_irq;
        end
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            test_done();
        end
    end

    // ****
    // Helpers
    // ****
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'b010;
        // Each phase ends at the edge that samples hready high
        do begin
            @(posedge sys_clk);
        end while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(posedge sys_clk);
        end while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask : wr

    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask : rdc

    function automatic mrxc_ev_t exp_ev(mrxc_ctl_t c, int len, logic [15:0] typ,
                                        logic [4:0] e);
        mrxc_ev_t v;
        int f;
        f = (typ == 16'h8100) ? 32'h0800 : 32'(typ);
        v.parity = e[4];
        v.overflow = e[3];
        v.fcs = e[2] | (e[0] & !c.skip_fcs_check);
        v.align = e[0] & e[1] & !c.skip_fcs_check;
        v.oversize = !c.accept_oversize_frames && len > ((typ == 16'h8100) ? 1522 : 1518);
        v.length = !c.skip_length_check && len >= 64 && f <= 1500
            && (len - ((typ == 16'h8100) ? 22 : 18)) != ((f > 46) ? f : 46);
        v.good = !(v.parity | v.overflow | v.fcs | v.align | v.oversize | v.length);
        return v;
    endfunction : exp_ev

    task automatic run_frame(input mrxc_ctl_t c, input int len, input logic [15:0] typ,
                             input logic [4:0] e);
        mrxc_ev_t v;
        logic keep, rj;
        logic [31:0] r;
        int d0;
        v = exp_ev(c, len, typ, e);
        rj = len < 64 && !c.accept_runt_frames;
        keep = !rj && !(v.oversize | v.fcs | v.overflow | v.parity)
            && (typ != 16'h8808 || c.forward_control_frames);
        wr(32'h50, {17'h0, c});
        ahb(1'b0, 32'h54, 32'h0, r);
        d0 = n_done;
        phy.send(len, typ, e, 0);
        repeat (2) @(posedge sys_clk);
        chk(32'(n_done - d0), 32'h1);
        chk(cap_keep, keep);
        if (keep) chk(cap_len, len - (c.remove_fcs ? 4 : 0));
        if (!rj && typ != 16'h8808) begin
            chk(cap_ev, v);
            chk(cap_irq, |(v & c[14:8]));
            rdc(32'h54, {16'h0, 1'b0, v, 8'h00});
            chk(rx_irq, 1'b0);
        end
        $display("Test frame of %0d bytes done", len);
    endtask : run_frame

    task automatic halt(input logic [14:0] c2, input int gap, input logic imm,
                        input int exp_n);
        int d0;
        wr(32'h50, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk(receive_stopped_flag, 1'b0);
        d0 = n_done;
        fork
            phy.send(100, 16'h0800, 5'h00, gap);
            begin
                repeat (gap > 0 ? 2 : 40) @(posedge sys_clk);
                if (imm) begin
                    immediate_stop_command <= 1'b1;
                    @(posedge sys_clk);
                    immediate_stop_command <= 1'b0;
                    repeat (2) @(posedge sys_clk);
                    chk(receive_stopped_flag, 1'b1);
                end else begin
                    wr(32'h50, {17'h0, c2});
                end
            end
        join
        repeat (2) @(posedge sys_clk);
        chk(32'(n_done - d0), 32'(exp_n));
        if (!imm) begin
            chk(receive_stopped_flag, 1'b1);
            phy.send(80, 16'h0800, 5'h00, 0);
            repeat (2) @(posedge sys_clk);
            chk(32'(n_done - d0), 32'(exp_n));
        end
        $display("Test stop case done");
    endtask : halt

    // ****
    // Main sequence
    // ****
    initial begin
        {rst_b, soft_rst, hsel, hwrite, immediate_stop_command} = 5'h00;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        hsize = 3'b010;
        {fail_count, n_checks, cyc, n_done} = {32'h0, 32'h0, 32'h0, 32'h0};
        void'($urandom(32'h98E1));
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rdc(32'h50, 32'h0);
        rdc(32'h54, 32'h8000);
        rdc(32'h58, 32'h0);
        chk(hresp, 1'b0);
        wr(32'h54, 32'h7FFF);
        wr(32'h58, 32'h7FFF);
        rdc(32'h54, 32'h8000);
        rdc(32'h50, 32'h0);
        wr(32'h50, 32'h7FFF);
        soft_rst <= 1'b1;
        @(posedge sys_clk);
        soft_rst <= 1'b0;
        rdc(32'h50, 32'h7FFE);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rdc(32'h50, 32'h0);
        $display("Test register reset done");
        for (int i = 0; i < 3; i++) begin
            run_frame(15'h7F01 | 15'(($urandom % 2) << 4), 64 + $urandom % 1455,
                16'h0800, 5'h00);
        end
        run_frame(15'h7F01, 100, 16'h0800, 5'h01);
        run_frame(15'h7F01, 100, 16'h0800, 5'h03);
        run_frame(15'h7F01, 100, 16'h0800, 5'h04);
        run_frame(15'h7F01, 100, 16'h0800, 5'h08);
        run_frame(15'h7F01, 100, 16'h0800, 5'h10);
        run_frame(15'h7F01, 64, 16'h0064, 5'h00);
        run_frame(15'h7F81, 64, 16'h0064, 5'h00);
        run_frame(15'h7F41, 100, 16'h0800, 5'h01);
        run_frame(15'h7F01, 1519, 16'h0800, 5'h00);
        run_frame(15'h7F01, 1522, 16'h8100, 5'h00);
        run_frame(15'h7F01, 1523, 16'h8100, 5'h00);
        run_frame(15'h7F05, 1519, 16'h0800, 5'h00);
        run_frame(15'h7F01, 63, 16'h0800, 5'h00);
        run_frame(15'h7F09, 63, 16'h0800, 5'h00);
        run_frame(15'h7F11, 200, 16'h0800, 5'h00);
        run_frame(15'h7F01, 80, 16'h8808, 5'h00);
        run_frame(15'h7F21, 80, 16'h8808, 5'h00);
        run_frame(15'h4001, 100, 16'h0800, 5'h01);
        halt(15'h0003, 0, 1'b0, 1);
        halt(15'h0000, 0, 1'b0, 1);
        halt(15'h0000, 8, 1'b0, 0);
        halt(15'h0001, 0, 1'b1, 0);
        test_done();
    end
endmodule : tb
